//--- gp2_apb_slave.sv
// APB slave with one access-phase cycle, feeding the port core
`include "gp2_consts.svh"
module gp2_apb_slave
    import gp2_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  psel,
    input  wire logic  penable,
    input  wire logic  pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic  rmw_in,
    gp2_reg_if.bus     rif,
    output logic [31:0] prdata,
    output logic       pready,
    output logic       pslverr
);
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        setup;

    function automatic gp2_sel_t decode(input logic [7:0] a);
        unique case (a)
            `GP2_OFS_DATA: decode = GP2_SEL_DATA;
            `GP2_OFS_DIR:  decode = GP2_SEL_DIR;
            `GP2_OFS_PULL: decode = GP2_SEL_PULL;
            `GP2_OFS_STBY: decode = GP2_SEL_STBY;
            default:       decode = GP2_SEL_NONE;
        endcase
    endfunction : decode

    assign setup      = psel & ~penable;
    assign rif.sel    = decode(paddr);
    assign rif.wdata  = pwdata[7:0];
    assign rif.rmw    = rmw_in;
    // Writes land at the completing edge only; unmapped ones are dropped
    assign rif.wr_stb = psel & penable & pready_r & pwrite & (decode(paddr) != GP2_SEL_NONE);

    always_comb
    begin
        pready_nxt  = setup;
        pslverr_nxt = setup & (decode(paddr) == GP2_SEL_NONE);
        prdata_nxt  = (setup & ~pwrite) ? {24'h000000, rif.rdata} : 32'h00000000;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
        else
        begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
endmodule : gp2_apb_slave

//--- gp2_consts.svh
// Register offsets, field positions and reset values of the two-line port
`ifndef GP2_CONSTS_SVH
`define GP2_CONSTS_SVH
`define GP2_OFS_DATA  8'h00
`define GP2_OFS_DIR   8'h04
`define GP2_OFS_PULL  8'h08
`define GP2_OFS_STBY  8'h0C
`define GP2_LINE_MASK 8'h06
`define GP2_DATA_RST  8'h00
`define GP2_DIR_RST   8'h00
`define GP2_PULL_RST  8'h00
`define GP2_STBY_RST  8'h00
`define GP2_FLOAT_BIT 0
`endif

//--- gp2_pads_model.sv
// Board-side model of the two port lines: pad drivers, pull-ups, open pads
module gp2_pads_model
    import gp2_pkg::*;
(
    input  wire logic       clk,
    input  wire gp2_lines_t pin_out,
    input  wire gp2_lines_t pin_oe,
    input  wire gp2_lines_t pull_on,
    input  wire gp2_lines_t ext_en,
    input  wire gp2_lines_t ext_val,
    output gp2_lines_t      pin_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    gp2_lines_t flt_r;
    initial flt_r = 2'h1;
    // Open pad wanders each cycle so no stale level passes as valid
    always @(posedge clk)
        flt_r <= ~flt_r;
    always_comb
    begin
        for (int i = 1; i <= 2; i++)
        begin
            if (pin_oe[i])
                pin_lvl[i] = pin_out[i];
            else if (ext_en[i])
                pin_lvl[i] = ext_val[i];
            else if (pull_on[i])
                pin_lvl[i] = 1'h1;
            else
                pin_lvl[i] = flt_r[i];
        end
    end
endmodule : gp2_pads_model

//--- gp2_pkg.sv
// Types shared by the port modules
package gp2_pkg;
    typedef logic [7:0] gp2_byte_t;
    typedef logic [2:1] gp2_lines_t;
    typedef enum logic [2:0]
    {
        GP2_SEL_NONE = 3'b000,
        GP2_SEL_DATA = 3'b001,
        GP2_SEL_DIR  = 3'b010,
        GP2_SEL_PULL = 3'b011,
        GP2_SEL_STBY = 3'b100
    } gp2_sel_t;
endpackage : gp2_pkg

//--- gp2_port.sv
// Two-line general-purpose port with data latch, direction and pull-up control
//
// Functional notes
// R01: Direction bit one makes line an output
// R02: Output line drives the data latch bit
// R03: Data write reaches output lines directly
// R04: Output line read returns latch bit
// R05: Direction bit zero makes line an input
// R06: Input line write only updates latch
// R07: Input line read returns sampled pin
// R08: Read-modify-write read always returns latch
// R09: Peripheral input lines still read pin level
// R10: Software disables peripheral outputs before port use
// R11: Reset clears all direction bits
// R12: Float bit in standby floats, blocks inputs
// R13: Standby without float keeps pin state
// R14: Pull-up bit connects or removes pull-up
// R15: Pull-up off while driving low
// R16: Only bits two and one exist
// R17: Unused bits ignore writes, read zero
//
// Chosen here: register access over APB and the register offsets.
`include "gp2_consts.svh"
module gp2_port
    import gp2_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        RMW_READ,
    input  wire logic        STANDBY_REQ,
    input  wire gp2_lines_t  PIN_IN,
    output gp2_lines_t       PIN_OUT,
    output gp2_lines_t       PIN_OE,
    output gp2_lines_t       PULLUP_ON,
    output gp2_lines_t       PERIPH_IN
);
    gp2_reg_if rif ();

    gp2_byte_t  data_r;
    gp2_byte_t  data_nxt;
    gp2_byte_t  dir_r;
    gp2_byte_t  dir_nxt;
    gp2_byte_t  pull_r;
    gp2_byte_t  pull_nxt;
    gp2_byte_t  stby_r;
    gp2_byte_t  stby_nxt;
    gp2_lines_t out_r;
    gp2_lines_t out_nxt;
    gp2_lines_t oe_r;
    gp2_lines_t oe_nxt;
    gp2_lines_t pu_r;
    gp2_lines_t pu_nxt;
    gp2_lines_t periph_r;
    gp2_lines_t periph_nxt;
    gp2_lines_t pin_sync;
    gp2_lines_t pin_level;
    logic       float_on;
    logic       hold_on;

    function automatic gp2_byte_t keep_lines(input gp2_byte_t v);
        keep_lines = v & `GP2_LINE_MASK; // R16 R17
    endfunction : keep_lines

    gp2_apb_slave u_apb
    (
        .clk     (CLK),
        .rst     (RST),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .rmw_in  (RMW_READ),
        .rif     (rif.bus),
        .prdata  (PRDATA),
        .pready  (PREADY),
        .pslverr (PSLVERR)
    );

    gp2_sync3 u_sync
    (
        .clk  (CLK),
        .rst  (RST),
        .din  (PIN_IN),
        .dout (pin_sync)
    );

    assign float_on = STANDBY_REQ & stby_r[`GP2_FLOAT_BIT]; // R12
    assign hold_on  = STANDBY_REQ & ~stby_r[`GP2_FLOAT_BIT]; // R13
    // Blocked input reads as low so an open pin cannot leak into logic
    assign pin_level = float_on ? 2'h0 : pin_sync; // R12

    // Register file
    always_comb
    begin
        data_nxt = data_r;
        dir_nxt  = dir_r;
        pull_nxt = pull_r;
        stby_nxt = stby_r;
        if (rif.wr_stb)
        begin
            unique case (rif.sel)
                GP2_SEL_DATA: data_nxt = keep_lines(rif.wdata); // R03 R06
                GP2_SEL_DIR:  dir_nxt  = keep_lines(rif.wdata); // R01 R05
                GP2_SEL_PULL: pull_nxt = keep_lines(rif.wdata); // R14
                GP2_SEL_STBY: stby_nxt = rif.wdata & 8'h01;
                GP2_SEL_NONE: data_nxt = data_r;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            data_r <= `GP2_DATA_RST;
            dir_r  <= `GP2_DIR_RST; // R11
            pull_r <= `GP2_PULL_RST;
            stby_r <= `GP2_STBY_RST;
        end
        else
        begin
            data_r <= data_nxt;
            dir_r  <= dir_nxt;
            pull_r <= pull_nxt;
            stby_r <= stby_nxt;
        end
    end

    // Read path: data reads give latch for outputs and RMW reads, pin level otherwise; other registers read back
    always_comb
    begin
        rif.rdata = 8'h00;
        unique case (rif.sel)
            GP2_SEL_DATA:
            begin
                rif.rdata[2:1] = rif.rmw ? data_r[2:1] // R08
                               : (dir_r[2:1] & data_r[2:1])
                               | (~dir_r[2:1] & pin_level); // R04 R07 R09
            end
            GP2_SEL_DIR:  rif.rdata = dir_r;
            GP2_SEL_PULL: rif.rdata = pull_r;
            GP2_SEL_STBY: rif.rdata = stby_r;
            GP2_SEL_NONE: rif.rdata = 8'h00;
        endcase
    end

    // Pin drivers
    always_comb
    begin
        if (float_on)
        begin
            oe_nxt  = 2'h0; // R12
            out_nxt = out_r;
        end
        else if (hold_on)
        begin
            oe_nxt  = oe_r; // R13
            out_nxt = out_r;
        end
        else
        begin
            oe_nxt  = dir_r[2:1]; // R01 R05 R06
            out_nxt = data_r[2:1]; // R02 R03
        end
        // Pull-up still acts on a floated pin
        pu_nxt     = pull_r[2:1] & ~(oe_nxt & ~out_nxt); // R14 R15
        periph_nxt = pin_level; // R09
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            out_r    <= 2'h0;
            oe_r     <= 2'h0;
            pu_r     <= 2'h0;
            periph_r <= 2'h0;
        end
        else
        begin
            out_r    <= out_nxt;
            oe_r     <= oe_nxt;
            pu_r     <= pu_nxt;
            periph_r <= periph_nxt;
        end
    end

    assign PIN_OUT   = out_r;
    assign PIN_OE    = oe_r;
    assign PULLUP_ON = pu_r;
    assign PERIPH_IN = periph_r;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_data_wr;
        rif.wr_stb && rif.sel == GP2_SEL_DATA && !STANDBY_REQ;
    endsequence

    sequence s_data_rd;
        PSEL && !PENABLE && !PWRITE && PADDR == `GP2_OFS_DATA;
    endsequence

    property p_out_dir;
        dir_r[1] && !STANDBY_REQ |=> PIN_OE[1];
    endproperty
    a_out_dir: assert property (p_out_dir) else $error("output line not enabled"); // R01

    property p_drive_latch;
        !STANDBY_REQ |=> PIN_OUT == $past(data_r[2:1]);
    endproperty
    a_drive_latch: assert property (p_drive_latch) else $error("pin not latch"); // R02

    property p_write_to_pin;
        s_data_wr ##1 !STANDBY_REQ |=> PIN_OUT == $past(rif.wdata[2:1], 2);
    endproperty
    a_write_to_pin: assert property (p_write_to_pin) else $error("write lost"); // R03

    property p_read_out;
        s_data_rd and (dir_r[2:1] == 2'h3 && !RMW_READ)
            |=> PRDATA[2:1] == $past(data_r[2:1]);
    endproperty
    a_read_out: assert property (p_read_out) else $error("output read wrong"); // R04

    property p_in_undriven;
        !dir_r[2] && !STANDBY_REQ |=> !PIN_OE[2];
    endproperty
    a_in_undriven: assert property (p_in_undriven) else $error("input driven"); // R05 R06

    property p_read_in;
        s_data_rd and (dir_r[2:1] == 2'h0 && !RMW_READ)
            |=> PRDATA[2:1] == $past(pin_level);
    endproperty
    a_read_in: assert property (p_read_in) else $error("input read wrong"); // R07

    property p_read_rmw;
        s_data_rd and RMW_READ |=> PRDATA[2:1] == $past(data_r[2:1]);
    endproperty
    a_read_rmw: assert property (p_read_rmw) else $error("rmw read wrong"); // R08

    property p_periph;
        !float_on |=> PERIPH_IN == $past(pin_sync);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral input wrong"); // R09

    property p_reset_dir;
        $fell(RST) |-> dir_r == 8'h00 && PIN_OE == 2'h0;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("reset not input"); // R11

    property p_float;
        float_on |=> PIN_OE == 2'h0 && PERIPH_IN == 2'h0;
    endproperty
    a_float: assert property (p_float) else $error("float failed"); // R12

    property p_hold;
        hold_on |=> PIN_OE == $past(PIN_OE) && PIN_OUT == $past(PIN_OUT);
    endproperty
    a_hold: assert property (p_hold) else $error("standby state changed"); // R13

    property p_pull_on;
        pull_r[2] |=> PULLUP_ON[2] || (PIN_OE[2] && !PIN_OUT[2]);
    endproperty
    a_pull_on: assert property (p_pull_on) else $error("pull-up missing"); // R14

    property p_pull_low;
        PIN_OE[1] && !PIN_OUT[1] |-> !PULLUP_ON[1];
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("pull-up on low"); // R15

    property p_out_dir2;
        dir_r[2] && !STANDBY_REQ |=> PIN_OE[2];
    endproperty
    a_out_dir2: assert property (p_out_dir2) else $error("output line not enabled"); // R01

    property p_in_undriven1;
        !dir_r[1] && !STANDBY_REQ |=> !PIN_OE[1];
    endproperty
    a_in_undriven1: assert property (p_in_undriven1) else $error("input driven"); // R05 R06

    property p_pull_low2;
        PIN_OE[2] && !PIN_OUT[2] |-> !PULLUP_ON[2];
    endproperty
    a_pull_low2: assert property (p_pull_low2) else $error("pull-up on low"); // R15

    property p_float_pull;
        float_on && pull_r[1] |=> PULLUP_ON[1];
    endproperty
    a_float_pull: assert property (p_float_pull) else $error("pull-up lost in standby"); // R14

    property p_unused;
        ((data_r | dir_r | pull_r) & ~`GP2_LINE_MASK) == 8'h00
            && PRDATA[31:8] == 24'h000000;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set"); // R16 R17
endmodule : gp2_port

//--- gp2_reg_if.sv
// Register access strobes between the bus slave and the port core
interface gp2_reg_if;
    import gp2_pkg::*;
    logic      wr_stb;
    logic      rmw;
    gp2_sel_t  sel;
    gp2_byte_t wdata;
    gp2_byte_t rdata;
    modport bus  (output wr_stb, output rmw, output sel, output wdata, input rdata);
    modport core (input wr_stb, input rmw, input sel, input wdata, output rdata);
endinterface : gp2_reg_if

//--- gp2_sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
module gp2_sync3
    import gp2_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire gp2_lines_t din,
    output gp2_lines_t      dout
);
    gp2_lines_t s1_r;
    gp2_lines_t s2_r;
    gp2_lines_t s3_r;
    gp2_lines_t dout_r;
    gp2_lines_t dout_nxt;

    always_comb
    begin
        // Only the agreeing stages are looked at; the first stage may be metastable
        dout_nxt = (s2_r & s3_r) | (dout_r & (s2_r ^ s3_r));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_r   <= 2'h0;
            s2_r   <= 2'h0;
            s3_r   <= 2'h0;
            dout_r <= 2'h0;
        end
        else
        begin
            s1_r   <= din;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            dout_r <= dout_nxt;
        end
    end

    assign dout = dout_r;
endmodule : gp2_sync3

//--- two_bit_gpio_port_with_pullup_test.sv
// Self-checking bench of the two-line port
`include "gp2_consts.svh"
module two_bit_gpio_port_with_pullup_test
    import gp2_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {gp2_lines_t dir, dat, pul, ext;} gp2_row_t;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, rmw_read = 0, stby = 0, er;
    gp2_lines_t  pin_in, pin_out, pin_oe, pull_on, periph;
    gp2_lines_t  ext_en = 2'h0, ext_val = 2'h0, lvl;
    int          n_fail = 0, samples_checked = 0;
    gp2_row_t    r;
    gp2_row_t    rows[4] = '{'{2'h0, 2'h3, 2'h3, 2'h2}, '{2'h3, 2'h2, 2'h3, 2'h1},
                             '{2'h1, 2'h0, 2'h2, 2'h2}, '{2'h2, 2'h1, 2'h1, 2'h1}};
    always #50 clk = ~clk;
    gp2_port dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RMW_READ(rmw_read),
        .STANDBY_REQ(stby), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PULLUP_ON(pull_on), .PERIPH_IN(periph));
    gp2_pads_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_on(pull_on), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic rmw);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'hFFFFFF, d};
        rmw_read <= rmw;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        rmw_read <= 1'h0;
        @(posedge clk);
    endtask : apb
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk("oe_rst", pin_oe, 2'h0);
        apb(0, `GP2_OFS_DIR, 8'h00, 0);
        chk("dir_rst", rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            r = rows[i];
            ext_en <= ~r.dir;
            ext_val <= r.ext;
            apb(1, `GP2_OFS_DIR, {5'h1F, r.dir, 1'h1}, 0);
            apb(1, `GP2_OFS_DATA, {5'h1F, r.dat, 1'h1}, 0);
            apb(1, `GP2_OFS_PULL, {5'h1F, r.pul, 1'h1}, 0);
            repeat (6) @(posedge clk);
            lvl = (r.dir & r.dat) | (~r.dir & r.ext);
            chk("oe", pin_oe, r.dir);
            chk("out", pin_out & r.dir, r.dat & r.dir);
            chk("pull", pull_on, r.pul & ~(r.dir & ~r.dat));
            chk("periph", periph, lvl);
            apb(0, `GP2_OFS_DATA, 8'h00, 0);
            chk("rd", rd, {29'h0, lvl, 1'h0});
            apb(0, `GP2_OFS_DATA, 8'h00, 1);
            chk("rmw", rd, {29'h0, r.dat, 1'h0});
            apb(0, `GP2_OFS_PULL, 8'h00, 0);
            chk("pul_rd", rd, {29'h0, r.pul, 1'h0});
        end
        // Undriven input lines settle through the pull-ups
        ext_en <= 2'h0;
        apb(1, `GP2_OFS_DIR, 8'h00, 0);
        apb(1, `GP2_OFS_PULL, 8'h06, 0);
        repeat (6) @(posedge clk);
        apb(0, `GP2_OFS_DATA, 8'h00, 0);
        chk("pull_rd", rd, 32'h6);
        apb(1, `GP2_OFS_STBY, 8'h00, 0);
        apb(1, `GP2_OFS_DIR, 8'h06, 0);
        apb(1, `GP2_OFS_DATA, 8'h04, 0);
        stby <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1, `GP2_OFS_DATA, 8'h02, 0);
        chk("keep_oe", pin_oe, 2'h3);
        chk("keep_out", pin_out, 2'h2);
        stby <= 1'h0;
        apb(1, `GP2_OFS_STBY, 8'h01, 0);
        stby <= 1'h1;
        repeat (4) @(posedge clk);
        chk("flt_oe", pin_oe, 2'h0);
        chk("flt_in", periph, 2'h0);
        chk("flt_pu", pull_on, 2'h3);
        stby <= 1'h0;
        apb(0, 8'h10, 8'h00, 0);
        chk("bad_err", er, 1'h1);
        chk("bad_rd", rd, 32'h0);
        // Second reset while both lines drive
        rst <= 1'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk("oe_rst2", pin_oe, 2'h0);
        apb(0, `GP2_OFS_DIR, 8'h00, 0);
        chk("dir_rst2", rd, 32'h0);
        print_verdict();
    end
endmodule : two_bit_gpio_port_with_pullup_test
